// ==== shared/sadc_pkg.sv ====
// Purpose: constants and types for the converter sequencer and result buffer
// Assumes: 16-bit register port addressed by word index, one clock
// Notes: register index, field, code and type sections follow
package sadc_pkg;
	// ---------------------------------------------------------------
	// register indices
	// ---------------------------------------------------------------
	localparam logic [5:0] ADDR_CON1     = 6'h00;
	localparam logic [5:0] ADDR_CON2     = 6'h01;
	localparam logic [5:0] ADDR_CON3     = 6'h02;
	localparam logic [5:0] ADDR_CON5     = 6'h03;
	localparam logic [5:0] ADDR_SCAN_LO  = 6'h04;
	localparam logic [5:0] ADDR_SCAN_HI  = 6'h05;
	localparam logic [5:0] ADDR_HIT_LO   = 6'h06;
	localparam logic [5:0] ADDR_HIT_HI   = 6'h07;
	localparam logic [5:0] ADDR_CU_LO    = 6'h08;
	localparam logic [5:0] ADDR_CU_HI    = 6'h09;
	localparam logic [5:0] ADDR_SEL      = 6'h0A;
	localparam logic [5:0] ADDR_BUF_BASE = 6'h20;
	// ---------------------------------------------------------------
	// control one fields and register masks
	// ---------------------------------------------------------------
	localparam int         BIT_ENABLE    = 15;
	localparam int         BIT_SIDL      = 13;
	localparam int         BIT_RES12     = 10;
	localparam int         BIT_ASTART    = 2;
	localparam int         BIT_SAMPLE_CONTROL      = 1;
	localparam int         BIT_DONE      = 0;
	localparam logic [15:0] CON1_MASK    = 16'hA7F7;
	localparam logic [15:0] CON2_MASK    = 16'h007C;
	localparam logic [15:0] CON3_MASK    = 16'h1FFF;
	localparam logic [15:0] CON5_MASK    = 16'h8003;
	localparam logic [15:0] ZERO16       = 16'h0000;
	localparam logic [7:0]  CLKDIV_MAX   = 8'h3F;
	// ---------------------------------------------------------------
	// codes
	// ---------------------------------------------------------------
	localparam logic [3:0] TRIG_MANUAL   = 4'h0;
	localparam logic [3:0] TRIG_EXTINT0  = 4'h1;
	localparam logic [3:0] TRIG_TIMER3   = 4'h2;
	localparam logic [3:0] TRIG_TIMER5   = 4'h3;
	localparam logic [3:0] TRIG_CHARGE   = 4'h4;
	localparam logic [3:0] TRIG_TIMER1   = 4'h5;
	localparam logic [3:0] TRIG_COUNTER  = 4'h7;
	localparam logic [1:0] FMT_UINT      = 2'h0;
	localparam logic [1:0] FMT_SINT      = 2'h1;
	localparam logic [1:0] FMT_UFRAC     = 2'h2;
	localparam logic [1:0] FMT_SFRAC     = 2'h3;
	localparam logic [1:0] CMP_LESS      = 2'h0;
	localparam logic [1:0] CMP_GREATER   = 2'h1;
	localparam logic [1:0] CMP_INSIDE    = 2'h2;
	localparam logic [1:0] CMP_OUTSIDE   = 2'h3;
	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [4:0]  ch;
		logic [11:0] data;
	} sadc_sample_t;
	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_SAMPLE  = 2'b01,
		ST_CONVERT = 2'b10
	} sadc_state_t;
endpackage : sadc_pkg

// ==== hdl/sadc_core.sv ====
// Purpose: sequencer, control registers and dual-port result buffer
// Assumes: same-clock register port, same-clock timer/charge-unit events
// Notes: result path has a two-entry buffer; external interrupt pin is synchronised
module sadc_core #(
	parameter int BUF_WORDS = 32,
	parameter int CHANNELS  = 32
) (
	// clock and reset
	input  wire logic                  clk_sys,
	input  wire logic                  reset_n,
	// register port
	input  wire logic [5:0]            reg_addr,
	input  wire logic                  reg_wr,
	input  wire logic [15:0]           reg_wdata,
	output logic      [15:0]           reg_rdata,
	// power state and trigger events
	input  wire logic                  idle_mode,
	input  wire logic                  trig_timer1,
	input  wire logic                  trig_timer3,
	input  wire logic                  trig_timer5,
	input  wire logic                  trig_charge_unit,
	input  wire logic                  ext_external_interrupt_zero_pin,
	// analog core control
	output logic                       sh_sample,
	output logic                       sar_start,
	output logic      [4:0]            sar_channel,
	output logic                       sar_resolution_12,
	output logic                       charge_unit_select,
	// conversion results
	input  wire logic                  res_valid,
	output logic                       res_ready,
	input  wire sadc_pkg::sadc_sample_t res_data,
	// interrupt event
	output logic                       converter_interrupt_flag
);
	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	logic [15:0]           con1_reg, con2_reg, con3_reg, con5_reg, sel_reg;
	logic [31:0]           scan_reg, hit_reg, cu_reg, hit_next;
	logic [15:0]           buf_mem [BUF_WORDS];
	sadc_pkg::sadc_state_t state_reg;
	logic [7:0]            tad_cnt_reg;
	logic [4:0]            sample_control_cnt_reg, conv_cnt_reg;
	logic [2:0]            external_interrupt_zero_sync_reg;
	logic                  external_interrupt_zero_level_reg, external_interrupt_zero_prev_reg;
	logic [4:0]            ch_reg, ch_next;

	logic enable, running, tad_tick, trig_hit, end_sample, drain_go, wr_any;
	logic [1:0] fmt, cmp_mode;
	logic [3:0] trig_src;
	logic [15:0] fmt_val, thr_lo, thr_hi;
	logic cmp_match;

	assign enable   = con1_reg[sadc_pkg::BIT_ENABLE];
	assign running  = enable && !(con1_reg[sadc_pkg::BIT_SIDL] && idle_mode);
	assign fmt      = con1_reg[9:8];
	assign trig_src = con1_reg[7:4];
	assign cmp_mode = con5_reg[1:0];
	assign wr_any   = reg_wr;

	// ---------------------------------------------------------------
	// two-entry result buffer
	// ---------------------------------------------------------------
	sadc_pkg::sadc_sample_t fifo_mem [2];
	logic                   fifo_wp_reg, fifo_rp_reg;
	logic [1:0]             fifo_cnt_reg;
	logic                   out_valid;
	sadc_pkg::sadc_sample_t out_data;

	assign res_ready = (fifo_cnt_reg != 2'd2);
	assign out_valid = (fifo_cnt_reg != 2'd0);
	assign out_data  = fifo_mem[fifo_rp_reg];

	// fill and drain; the drain stalls while the converter is halted
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			fifo_wp_reg  <= 1'b0;
			fifo_rp_reg  <= 1'b0;
			fifo_cnt_reg <= 2'd0;
		end else begin
			if (res_valid && res_ready)
				fifo_wp_reg <= ~fifo_wp_reg;
			if (drain_go)
				fifo_rp_reg <= ~fifo_rp_reg;
			fifo_cnt_reg <= fifo_cnt_reg + 2'(res_valid && res_ready) - 2'(drain_go);
		end
	end

	// storage of buffered samples
	always_ff @(posedge clk_sys) begin
		if (res_valid && res_ready)
			fifo_mem[fifo_wp_reg] <= res_data;
	end

	// ---------------------------------------------------------------
	// external interrupt synchroniser
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			external_interrupt_zero_sync_reg  <= 3'h0;
			external_interrupt_zero_level_reg <= 1'b0;
			external_interrupt_zero_prev_reg  <= 1'b0;
		end else begin
			external_interrupt_zero_sync_reg <= {external_interrupt_zero_sync_reg[1:0], ext_external_interrupt_zero_pin};
			if (external_interrupt_zero_sync_reg[1] == external_interrupt_zero_sync_reg[2])
				external_interrupt_zero_level_reg <= external_interrupt_zero_sync_reg[2];
			external_interrupt_zero_prev_reg <= external_interrupt_zero_level_reg;
		end
	end

	// ---------------------------------------------------------------
	// conversion clock and sample timer
	// ---------------------------------------------------------------
	logic [7:0] div_lim;
	assign div_lim  = (con3_reg[7:0] > sadc_pkg::CLKDIV_MAX) ? sadc_pkg::CLKDIV_MAX : con3_reg[7:0];
	assign tad_tick = running && (tad_cnt_reg == div_lim);

	// divider: one tick every code+1 system cycles, code capped at 3F
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			tad_cnt_reg <= 8'h00;
		else if (!running || tad_tick)
			tad_cnt_reg <= 8'h00;
		else
			tad_cnt_reg <= tad_cnt_reg + 8'h01;
	end

	// counts conversion clock periods while sampling
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			sample_control_cnt_reg <= 5'h00;
		else if (state_reg != sadc_pkg::ST_SAMPLE)
			sample_control_cnt_reg <= 5'h00;
		else if (tad_tick && sample_control_cnt_reg != con3_reg[12:8])
			sample_control_cnt_reg <= sample_control_cnt_reg + 5'h01;
	end

	// ---------------------------------------------------------------
	// trigger selection
	// ---------------------------------------------------------------
	always_comb begin
		case (trig_src)
			sadc_pkg::TRIG_COUNTER: trig_hit = (sample_control_cnt_reg == con3_reg[12:8]);
			sadc_pkg::TRIG_TIMER1:  trig_hit = trig_timer1;
			sadc_pkg::TRIG_CHARGE:  trig_hit = trig_charge_unit;
			sadc_pkg::TRIG_TIMER5:  trig_hit = trig_timer5;
			sadc_pkg::TRIG_TIMER3:  trig_hit = trig_timer3;
			sadc_pkg::TRIG_EXTINT0: trig_hit = external_interrupt_zero_level_reg && !external_interrupt_zero_prev_reg;
			default:                trig_hit = 1'b0; // manual and unavailable codes
		endcase
	end

	// manual mode ends sampling when software clears sample control
	assign end_sample = running && state_reg == sadc_pkg::ST_SAMPLE
		&& ((trig_src == sadc_pkg::TRIG_MANUAL) ? !con1_reg[sadc_pkg::BIT_SAMPLE_CONTROL] : trig_hit);
	assign drain_go   = running && out_valid && state_reg == sadc_pkg::ST_CONVERT;

	// ---------------------------------------------------------------
	// result formatting and threshold compare
	// ---------------------------------------------------------------
	always_comb begin
		logic [11:0] raw;
		logic [11:0] sgn;
		raw = con1_reg[sadc_pkg::BIT_RES12] ? out_data.data : {2'b00, out_data.data[9:0]};
		sgn = con1_reg[sadc_pkg::BIT_RES12] ? {~raw[11], raw[10:0]}
			: {{2{~raw[9]}}, ~raw[9], raw[8:0]};
		case (fmt)
			sadc_pkg::FMT_UINT:  fmt_val = {4'h0, raw};
			sadc_pkg::FMT_SINT:  fmt_val = {{4{sgn[11]}}, sgn};
			sadc_pkg::FMT_UFRAC: fmt_val = con1_reg[sadc_pkg::BIT_RES12] ? {raw, 4'h0} : {raw[9:0], 6'h00};
			sadc_pkg::FMT_SFRAC: fmt_val = con1_reg[sadc_pkg::BIT_RES12] ? {sgn, 4'h0} : {sgn[9:0], 6'h00};
			default:             fmt_val = {4'h0, raw};
		endcase
	end

	assign thr_lo = buf_mem[{out_data.ch[4:1], 1'b0}];
	assign thr_hi = buf_mem[{out_data.ch[4:1], 1'b1}];

	// match test against the channel word or the window pair
	always_comb begin
		case (cmp_mode)
			sadc_pkg::CMP_LESS:    cmp_match = fmt_val < buf_mem[out_data.ch];
			sadc_pkg::CMP_GREATER: cmp_match = fmt_val > buf_mem[out_data.ch];
			sadc_pkg::CMP_INSIDE:  cmp_match = fmt_val >= thr_lo && fmt_val <= thr_hi;
			sadc_pkg::CMP_OUTSIDE: cmp_match = fmt_val < thr_lo || fmt_val > thr_hi;
			default:               cmp_match = 1'b0;
		endcase
	end

	// ---------------------------------------------------------------
	// dual-port result buffer
	// ---------------------------------------------------------------
	// converter side writes only while enabled, bus side only while off
	always_ff @(posedge clk_sys) begin
		if (drain_go && !con5_reg[15])
			buf_mem[out_data.ch] <= fmt_val;
		else if (wr_any && !enable && reg_addr >= sadc_pkg::ADDR_BUF_BASE)
			buf_mem[reg_addr[4:0]] <= reg_wdata;
	end

	// ---------------------------------------------------------------
	// control one: enable, format, trigger, sample and done
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			con1_reg <= sadc_pkg::ZERO16;
		end else begin
			if (wr_any && reg_addr == sadc_pkg::ADDR_CON1)
				con1_reg <= (reg_wdata & sadc_pkg::CON1_MASK & ~16'h0001)
					| {15'h0000, con1_reg[sadc_pkg::BIT_DONE] & reg_wdata[sadc_pkg::BIT_DONE]};
			if (end_sample)
				con1_reg[sadc_pkg::BIT_SAMPLE_CONTROL] <= 1'b0;
			if (state_reg == sadc_pkg::ST_IDLE && con1_reg[sadc_pkg::BIT_SAMPLE_CONTROL] && running)
				con1_reg[sadc_pkg::BIT_DONE] <= 1'b0;
			if (drain_go) begin
				con1_reg[sadc_pkg::BIT_DONE] <= 1'b1;
				if (con1_reg[sadc_pkg::BIT_ASTART])
					con1_reg[sadc_pkg::BIT_SAMPLE_CONTROL] <= 1'b1;
			end
		end
	end

	// other configuration registers
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			con2_reg <= sadc_pkg::ZERO16;
			con3_reg <= sadc_pkg::ZERO16;
			con5_reg <= sadc_pkg::ZERO16;
			sel_reg  <= sadc_pkg::ZERO16;
			scan_reg <= 32'h0000_0000;
			cu_reg   <= 32'h0000_0000;
		end else if (wr_any) begin
			case (reg_addr)
				sadc_pkg::ADDR_CON2:    con2_reg       <= reg_wdata & sadc_pkg::CON2_MASK;
				sadc_pkg::ADDR_CON3:    con3_reg       <= reg_wdata & sadc_pkg::CON3_MASK;
				sadc_pkg::ADDR_CON5:    con5_reg       <= reg_wdata & sadc_pkg::CON5_MASK;
				sadc_pkg::ADDR_SEL:     sel_reg        <= {11'h000, reg_wdata[4:0]};
				sadc_pkg::ADDR_SCAN_LO: scan_reg[15:0] <= reg_wdata;
				sadc_pkg::ADDR_SCAN_HI: scan_reg[31:16] <= reg_wdata;
				sadc_pkg::ADDR_CU_LO:   cu_reg[15:0]   <= reg_wdata;
				sadc_pkg::ADDR_CU_HI:   cu_reg[31:16]  <= reg_wdata;
				default: ;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// compare hit flags: software writes zero to clear, set wins
	// ---------------------------------------------------------------
	always_comb begin
		hit_next = hit_reg;
		if (wr_any && reg_addr == sadc_pkg::ADDR_HIT_LO)
			hit_next[15:0] = hit_reg[15:0] & reg_wdata;
		if (wr_any && reg_addr == sadc_pkg::ADDR_HIT_HI)
			hit_next[31:16] = hit_reg[31:16] & reg_wdata;
		if (drain_go && con5_reg[15] && cmp_match)
			hit_next[out_data.ch] = 1'b1;
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			hit_reg <= 32'h0000_0000;
		else
			hit_reg <= hit_next;
	end

	// ---------------------------------------------------------------
	// sequencer
	// ---------------------------------------------------------------
	// next selected channel after the current one, wrapping
	always_comb begin
		logic [4:0] idx;
		idx     = 5'h00;
		ch_next = ch_reg;
		for (int i = CHANNELS - 1; i >= 1; i--) begin
			idx = ch_reg + 5'(i);
			if (scan_reg[idx])
				ch_next = idx;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= sadc_pkg::ST_IDLE;
			sar_start <= 1'b0;
			ch_reg    <= 5'h00;
		end else begin
			sar_start <= 1'b0;
			if (!enable) begin
				state_reg <= sadc_pkg::ST_IDLE;
				ch_reg    <= con5_reg[15] ? ch_next : sel_reg[4:0];
			end else if (running) begin
				case (state_reg)
					sadc_pkg::ST_IDLE: begin
						if (con1_reg[sadc_pkg::BIT_SAMPLE_CONTROL])
							state_reg <= sadc_pkg::ST_SAMPLE;
					end
					sadc_pkg::ST_SAMPLE: begin
						if (end_sample) begin
							state_reg <= sadc_pkg::ST_CONVERT;
							sar_start <= 1'b1;
						end else if (!con1_reg[sadc_pkg::BIT_SAMPLE_CONTROL])
							state_reg <= sadc_pkg::ST_IDLE;
					end
					sadc_pkg::ST_CONVERT: begin
						if (drain_go) begin
							state_reg <= sadc_pkg::ST_IDLE;
							ch_reg    <= con5_reg[15] ? ch_next : sel_reg[4:0];
						end
					end
					default: state_reg <= sadc_pkg::ST_IDLE;
				endcase
			end
		end
	end

	// analog-facing outputs
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			sh_sample          <= 1'b0;
			sar_channel        <= 5'h00;
			sar_resolution_12  <= 1'b0;
			charge_unit_select <= 1'b0;
		end else begin
			sh_sample          <= running && state_reg == sadc_pkg::ST_SAMPLE;
			sar_channel        <= ch_reg;
			sar_resolution_12  <= con1_reg[sadc_pkg::BIT_RES12];
			charge_unit_select <= running && cu_reg[ch_reg] && state_reg != sadc_pkg::ST_IDLE;
		end
	end

	// conversion count and interrupt event
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			conv_cnt_reg             <= 5'h00;
			converter_interrupt_flag <= 1'b0;
		end else begin
			converter_interrupt_flag <= 1'b0;
			if (!enable)
				conv_cnt_reg <= 5'h00;
			else if (drain_go) begin
				if (conv_cnt_reg == con2_reg[6:2]) begin
					conv_cnt_reg             <= 5'h00;
					converter_interrupt_flag <= 1'b1;
				end else
					conv_cnt_reg <= conv_cnt_reg + 5'h01;
			end
		end
	end

	// ---------------------------------------------------------------
	// register read
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			reg_rdata <= sadc_pkg::ZERO16;
		else if (reg_addr >= sadc_pkg::ADDR_BUF_BASE)
			reg_rdata <= buf_mem[reg_addr[4:0]];
		else begin
			case (reg_addr)
				sadc_pkg::ADDR_CON1:    reg_rdata <= con1_reg;
				sadc_pkg::ADDR_CON2:    reg_rdata <= con2_reg;
				sadc_pkg::ADDR_CON3:    reg_rdata <= con3_reg;
				sadc_pkg::ADDR_CON5:    reg_rdata <= con5_reg;
				sadc_pkg::ADDR_SEL:     reg_rdata <= sel_reg;
				sadc_pkg::ADDR_SCAN_LO: reg_rdata <= scan_reg[15:0];
				sadc_pkg::ADDR_SCAN_HI: reg_rdata <= scan_reg[31:16];
				sadc_pkg::ADDR_HIT_LO:  reg_rdata <= hit_reg[15:0];
				sadc_pkg::ADDR_HIT_HI:  reg_rdata <= hit_reg[31:16];
				sadc_pkg::ADDR_CU_LO:   reg_rdata <= cu_reg[15:0];
				sadc_pkg::ADDR_CU_HI:   reg_rdata <= cu_reg[31:16];
				default:                reg_rdata <= sadc_pkg::ZERO16;
			endcase
		end
	end
endmodule : sadc_core

// ==== dv/sadc_props.sv ====
// Purpose: port-level checks for the converter sequencer
// Assumes: register writes at least two cycles apart
// Notes: keeps shadows of the enable, stop-in-idle and resolution bits
module sadc_props #(
	parameter int BUF_WORDS = 32,
	parameter int CHANNELS  = 32
) (
	// clock and reset
	input wire logic        clk_sys,
	input wire logic        reset_n,
	// register port
	input wire logic [5:0]  reg_addr,
	input wire logic        reg_wr,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	// converter side
	input wire logic        idle_mode,
	input wire logic        sar_start,
	input wire logic [4:0]  sar_channel,
	input wire logic        sar_resolution_12,
	input wire logic        converter_interrupt_flag
);
	logic en_q;
	logic sidl_q;
	logic res_q;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	// shadow of control one bits as software wrote them
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			en_q   <= 1'b0;
			sidl_q <= 1'b0;
			res_q  <= 1'b0;
		end else if (reg_wr && reg_addr == sadc_pkg::ADDR_CON1) begin
			en_q   <= reg_wdata[15];
			sidl_q <= reg_wdata[13];
			res_q  <= reg_wdata[10];
		end
	end
	a_start_one_cycle: assert property (sar_start |=> !sar_start)
		else $error("start pulse longer than one cycle");
	a_irq_single: assert property (converter_interrupt_flag |=> !converter_interrupt_flag)
		else $error("interrupt pulse longer than one cycle");
	a_chan_stable: assert property (sar_start |=> $stable(sar_channel)[*3])
		else $error("channel moved during conversion");
	a_res_copy: assert property (reg_wr && reg_addr == sadc_pkg::ADDR_CON1 |-> ##2 sar_resolution_12 == res_q)
		else $error("resolution output does not follow control");
	a_unmapped_zero: assert property (reg_addr inside {[6'h0B:6'h1F]} |=> reg_rdata == sadc_pkg::ZERO16)
		else $error("unmapped index read nonzero");
	a_con1_unimpl: assert property (reg_addr == sadc_pkg::ADDR_CON1 |=> (reg_rdata & ~sadc_pkg::CON1_MASK) == 16'h0000)
		else $error("unimplemented control bit reads one");
	a_off_quiet: assert property (!en_q && !$past(en_q, 3) |-> !sar_start)
		else $error("conversion started while disabled");
	a_idle_quiet: assert property (idle_mode && $past(idle_mode, 3) && sidl_q && $past(sidl_q, 3) |-> !sar_start)
		else $error("conversion started while halted in idle");
	c_start: cover property (sar_start);
	c_irq: cover property (converter_interrupt_flag);
	c_idle_stop: cover property (idle_mode && sidl_q);
endmodule : sadc_props
bind sadc_core sadc_props #(.BUF_WORDS(BUF_WORDS), .CHANNELS(CHANNELS)) u_props (.clk_sys(clk_sys),
	.reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.idle_mode(idle_mode), .sar_start(sar_start), .sar_channel(sar_channel),
	.sar_resolution_12(sar_resolution_12), .converter_interrupt_flag(converter_interrupt_flag));

// ==== dv/sadc_sar_model.sv ====
// Purpose: behavioural sample-and-hold and SAR core
// Assumes: one result per start, held until the buffer takes it
// Notes: slow stretches conversion; idle data lines toggle every cycle
module sadc_sar_model (
	// clock and reset
	input wire logic             clk_sys,
	input wire logic             reset_n,
	// converter control
	input wire logic             sar_start,
	input wire logic [4:0]       sar_channel,
	input wire logic             slow,
	// result handshake
	output logic                 res_valid,
	input wire logic             res_ready,
	output sadc_pkg::sadc_sample_t res_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [5:0] cnt_reg;
	logic [4:0] ch_reg;
	logic       junk_reg;
	// conversion timer, then result held until taken
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cnt_reg   <= 6'h00;
			ch_reg    <= 5'h00;
			res_valid <= 1'b0;
			junk_reg  <= 1'b0;
		end else begin
			junk_reg <= ~junk_reg;
			if (res_valid && res_ready) begin
				res_valid <= 1'b0;
			end
			if (sar_start) begin
				cnt_reg <= slow ? 6'h1E : 6'h04;
				ch_reg  <= sar_channel;
			end else if (cnt_reg == 6'h01) begin
				cnt_reg   <= 6'h00;
				res_valid <= 1'b1;
			end else if (cnt_reg != 6'h00) begin
				cnt_reg <= cnt_reg - 6'h01;
			end
		end
	end
	// raw code per channel; garbage while nothing is offered
	assign res_data = res_valid ? {ch_reg, 7'h1D, ch_reg} : {17{junk_reg}};
endmodule : sadc_sar_model

// ==== dv/testbench.sv ====
// Purpose: register-level tests of the converter sequencer
// Assumes: result word of channel 5 is raw 3A5 in twelve-bit mode
// Notes: interrupt rate stays at one pulse per conversion
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic                   clk_sys;
	logic                   reset_n;
	logic [5:0]             reg_addr;
	logic                   reg_wr;
	logic [15:0]            reg_wdata;
	logic [15:0]            reg_rdata;
	logic                   idle_mode;
	logic [4:0]             trg;
	logic                   slow;
	logic                   sh_sample;
	logic                   sar_start;
	logic [4:0]             sar_channel;
	logic                   sar_resolution_12;
	logic                   charge_unit_select;
	logic                   res_valid;
	logic                   res_ready;
	sadc_pkg::sadc_sample_t res_data;
	logic                   converter_interrupt_flag;
	logic [15:0]            rv;
	int                     err_count;
	int                     check_count;
	int                     irqs;
	sadc_core u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .idle_mode(idle_mode), .trig_timer1(trg[4]),
		.trig_timer3(trg[1]), .trig_timer5(trg[2]), .trig_charge_unit(trg[3]), .ext_external_interrupt_zero_pin(trg[0]),
		.sh_sample(sh_sample), .sar_start(sar_start), .sar_channel(sar_channel),
		.sar_resolution_12(sar_resolution_12), .charge_unit_select(charge_unit_select),
		.res_valid(res_valid), .res_ready(res_ready), .res_data(res_data),
		.converter_interrupt_flag(converter_interrupt_flag));
	sadc_sar_model u_sar (.clk_sys(clk_sys), .reset_n(reset_n), .sar_start(sar_start),
		.sar_channel(sar_channel), .slow(slow), .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data));
	// free-running system clock
	always #4 clk_sys = ~clk_sys;
	// count interrupt pulses
	always @(posedge clk_sys) begin
		if (converter_interrupt_flag === 1'b1) irqs++;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_addr  <= a;
		reg_wr    <= 1'b1;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rchk(input logic [5:0] a, input logic [15:0] e);
		@(posedge clk_sys);
		reg_addr <= a;
		repeat (2) @(posedge clk_sys);
		#1 rv = reg_rdata;
		chk(rv, e);
	endtask : rchk
	task automatic wait_done;
		int n;
		n = 0;
		rv = 16'h0000;
		while (rv[0] !== 1'b1 && n < 60) begin
			@(posedge clk_sys);
			reg_addr <= sadc_pkg::ADDR_CON1;
			repeat (2) @(posedge clk_sys);
			#1 rv = reg_rdata;
			n++;
		end
	endtask : wait_done
	task automatic print_verdict;
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : print_verdict
	// watchdog against a hung handshake
	initial begin
		repeat (30000) @(posedge clk_sys);
		err_count++;
		print_verdict();
	end
	// main sequence
	initial begin
		logic [15:0] fmt [4];
		logic [3:0]  cv;
		int          n0;
		fmt = '{16'h03A5, 16'hFBA5, 16'h3A50, 16'hBA50};
		clk_sys = 1'b0;
		reset_n = 1'b0;
		reg_addr = 6'h00;
		reg_wr = 1'b0;
		reg_wdata = 16'h0000;
		idle_mode = 1'b0;
		trg = 5'h00;
		slow = 1'b0;
		err_count = 0;
		check_count = 0;
		irqs = 0;
		repeat (4) @(posedge clk_sys);
		reset_n <= 1'b1;
		rchk(sadc_pkg::ADDR_CON1, 16'h0000);
		wr(sadc_pkg::ADDR_CON1, 16'h7FFD);
		rchk(sadc_pkg::ADDR_CON1, 16'h27F4);
		chk({15'h0000, sar_resolution_12}, 16'h0001);
		wr(sadc_pkg::ADDR_CON1, 16'h0000);
		wr(6'h10, 16'hFFFF);
		rchk(6'h10, 16'h0000);
		chk({15'h0000, sar_resolution_12}, 16'h0000);
		wr(sadc_pkg::ADDR_BUF_BASE + 6'h03, 16'h0123);
		rchk(sadc_pkg::ADDR_BUF_BASE + 6'h03, 16'h0123);
		wr(sadc_pkg::ADDR_CON1, 16'h8000);
		wr(sadc_pkg::ADDR_BUF_BASE + 6'h03, 16'hFFFF);
		rchk(sadc_pkg::ADDR_BUF_BASE + 6'h03, 16'h0123);
		wr(sadc_pkg::ADDR_CON1, 16'h0000);
		rchk(sadc_pkg::ADDR_BUF_BASE + 6'h03, 16'h0123);
		wr(sadc_pkg::ADDR_SEL, 16'h0005);
		wr(sadc_pkg::ADDR_CU_LO, 16'h0020);
		for (int f = 0; f < 4; f++) begin
			wr(sadc_pkg::ADDR_CON1, {6'h21, 2'(f), 8'h02});
			rchk(sadc_pkg::ADDR_CON1, {6'h21, 2'(f), 8'h02});
			chk({9'h000, sh_sample, charge_unit_select, sar_channel}, 16'h0065);
			wr(sadc_pkg::ADDR_CON1, {6'h21, 2'(f), 8'h00});
			wait_done();
			chk(rv, {6'h21, 2'(f), 8'h01});
			chk({9'h000, sh_sample, charge_unit_select, sar_channel}, 16'h0005);
			rchk(sadc_pkg::ADDR_BUF_BASE + 6'h05, fmt[f]);
		end
		// threshold detect: thresholds and scan set up before enable
		wr(sadc_pkg::ADDR_CON1, 16'h0000);
		wr(sadc_pkg::ADDR_CON5, 16'h8001);
		wr(sadc_pkg::ADDR_SCAN_LO, 16'h0020);
		wr(sadc_pkg::ADDR_BUF_BASE + 6'h05, 16'h0100);
		wr(sadc_pkg::ADDR_CON1, 16'h8402);
		wr(sadc_pkg::ADDR_CON1, 16'h8400);
		wait_done();
		rchk(sadc_pkg::ADDR_HIT_LO, 16'h0020);
		wr(sadc_pkg::ADDR_HIT_LO, 16'h0000);
		rchk(sadc_pkg::ADDR_HIT_LO, 16'h0000);
		wr(sadc_pkg::ADDR_CON1, 16'h0000);
		wr(sadc_pkg::ADDR_CON5, 16'h0000);
		slow <= 1'b1;
		for (int c = 1; c < 6; c++) begin // only available trigger codes
			cv = 4'(c);
			wr(sadc_pkg::ADDR_CON1, {8'h84, cv, 4'h2});
			repeat (10) @(posedge clk_sys);
			rchk(sadc_pkg::ADDR_CON1, {8'h84, cv, 4'h2});
			@(posedge clk_sys);
			trg <= 5'b00001 << (c - 1);
			repeat (c == 1 ? 4 : 1) @(posedge clk_sys);
			trg <= 5'h00;
			wait_done();
			chk(rv, {8'h84, cv, 4'h1});
		end
		chk(16'(irqs), 16'h000A);
		// no sleep entry here, so the RC clock choice never arises
		@(posedge clk_sys);
		slow      <= 1'b0;
		idle_mode <= 1'b1;
		wr(sadc_pkg::ADDR_CON3, 16'h0200);
		wr(sadc_pkg::ADDR_CON1, 16'h8476);
		repeat (400) @(posedge clk_sys);
		#1 chk({15'h0000, irqs > 24}, 16'h0001);
		wr(sadc_pkg::ADDR_CON1, 16'hA476);
		repeat (30) @(posedge clk_sys);
		#1 n0 = irqs;
		repeat (300) @(posedge clk_sys);
		#1 chk(16'(irqs), 16'(n0));
		wr(sadc_pkg::ADDR_CON1, 16'h8476);
		repeat (300) @(posedge clk_sys);
		#1 chk({15'h0000, irqs > n0}, 16'h0001);
		print_verdict();
	end
endmodule : testbench
